/* hw/rca_ctrl.sv */
// Audio control register, serial bus slave and power-up initial values
module rca_ctrl #(
    parameter logic [6:0] DEV_ADDR = rca_pkg::DEV_ADDR_DEF,
    parameter int unsigned HALF_LO = rca_pkg::HALF_LO_CYC,
    parameter int unsigned HALF_HI = rca_pkg::HALF_HI_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic backup_kept_i,
    input wire logic osc_stopped_i,
    output rca_pkg::rca_audio_t audio_o,
    output logic amp_on_o,
    output logic tone_sel_o,
    output logic tone_o,
    output rca_pkg::rca_clock_t clock_o,
    output rca_pkg::rca_charge_t charge_o,
    output logic mfp_o,
    output logic mfp_oe_n_o
);
    import rca_pkg::*;

    initial begin
        if (HALF_LO < 2 || HALF_HI < 2 || HALF_LO >= (1 << TONE_CNT_W)
            || HALF_HI >= (1 << TONE_CNT_W)) begin
            $error("tone half periods out of range");
        end
    end

    localparam logic [TONE_CNT_W-1:0] LO_END = TONE_CNT_W'(HALF_LO - 1);
    localparam logic [TONE_CNT_W-1:0] HI_END = TONE_CNT_W'(HALF_HI - 1);

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_p;
        logic sda_s1;
        logic sda_s2;
        logic sda_p;
        logic bk_s1;
        logic bk_s2;
        logic of_s1;
        logic of_s2;
        rca_bus_st_t st;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic rw;
        logic sda_low;
        logic [1:0] init_cnt;
        logic init_done;
        logic [TONE_CNT_W-1:0] tone_cnt;
        logic tone_q;
        logic [TONE_CNT_W-1:0] ft_cnt;
        logic ft_q;
        rca_audio_t aud;
        rca_clock_t clk;
        logic out_level;
        logic [3:0] key;
        logic diode;
        logic path;
    } rca_state_t;

    rca_state_t s_q;
    rca_state_t s_d;

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [7:0] rd_data;

    assign scl_rise = s_q.scl_s2 & ~s_q.scl_p;
    assign scl_fall = ~s_q.scl_s2 & s_q.scl_p;
    assign bus_start = s_q.scl_s2 & s_q.scl_p & s_q.sda_p & ~s_q.sda_s2;
    assign bus_stop = s_q.scl_s2 & s_q.scl_p & ~s_q.sda_p & s_q.sda_s2;

    // ------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_data = 8'h00;
        if (s_q.ptr == OFS_OSC) begin
            rd_data[BIT_OSC_DIS] = s_q.clk.oscillator_disable;
        end else if (s_q.ptr == OFS_CAL) begin
            rd_data[BIT_OUT] = s_q.out_level;
            rd_data[BIT_FT] = s_q.clk.frequency_test_enable;
            rd_data[BIT_CAL_SIGN] = s_q.clk.cal_sign;
            rd_data[4:0] = s_q.clk.cal_value;
        end else if (s_q.ptr == OFS_AUDIO) begin
            rd_data[BIT_PITCH] = s_q.aud.tone_512;
            rd_data[BIT_TONE_EN] = s_q.aud.tone_en;
            rd_data[BIT_MUTE] = s_q.aud.mute;
            rd_data[3:0] = s_q.aud.volume;
        end else if (s_q.ptr == OFS_CHARGE) begin
            rd_data[7:4] = s_q.key;
            rd_data[BIT_DIODE] = s_q.diode;
            rd_data[BIT_PATH] = s_q.path;
        end else if (s_q.ptr == OFS_FREEZE) begin
            rd_data[BIT_FREEZE] = s_q.clk.transfer_freeze;
        end else if (s_q.ptr == OFS_FAIL) begin
            rd_data[BIT_IRQ_EN] = s_q.clk.osc_fail_irq_enable;
            rd_data[BIT_OF] = s_q.clk.osc_failure_flag;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.scl_s1 = scl_i;
        s_d.scl_s2 = s_q.scl_s1;
        s_d.scl_p = s_q.scl_s2;
        s_d.sda_s1 = sda_i;
        s_d.sda_s2 = s_q.sda_s1;
        s_d.sda_p = s_q.sda_s2;
        s_d.bk_s1 = backup_kept_i;
        s_d.bk_s2 = s_q.bk_s1;
        s_d.of_s1 = osc_stopped_i;
        s_d.of_s2 = s_q.of_s1;

        // Power-up values once the backup flag has settled
        if (!s_q.init_done) begin
            s_d.init_cnt = s_q.init_cnt + 2'h1;
            if (s_q.init_cnt == INIT_WAIT) begin
                s_d.init_done = 1'b1;
                if (!s_q.bk_s2) begin
                    s_d.aud.volume = VOL_FIRST;
                    s_d.clk.oscillator_disable = 1'b0;
                    s_d.out_level = 1'b1;
                    s_d.clk.osc_failure_flag = 1'b1;
                    s_d.clk.osc_fail_irq_enable = 1'b0;
                    s_d.aud.tone_512 = 1'b1;
                    s_d.clk.cal_sign = 1'b0;
                    s_d.clk.cal_value = CAL_FIRST;
                end
            end
        end

        // Serial bus slave
        if (bus_stop || !s_q.init_done) begin
            s_d.st = BUS_IDLE;
            s_d.sda_low = 1'b0;
        end else if (bus_start) begin
            s_d.st = BUS_ADDR;
            s_d.bitcnt = 4'h0;
            s_d.sda_low = 1'b0;
        end else if (scl_rise) begin
            if (s_q.st == BUS_ADDR || s_q.st == BUS_WREG
                || s_q.st == BUS_WDATA) begin
                s_d.shreg = {s_q.shreg[6:0], s_q.sda_s2};
                s_d.bitcnt = s_q.bitcnt + 4'h1;
            end else if (s_q.st == BUS_RACK) begin
                s_d.rw = s_q.sda_s2;
            end
        end else if (scl_fall) begin
            case (s_q.st)
                BUS_ADDR: begin
                    if (s_q.bitcnt == 4'h8) begin
                        if (s_q.shreg[7:1] == DEV_ADDR) begin
                            s_d.rw = s_q.shreg[0];
                            s_d.sda_low = 1'b1;
                            s_d.st = BUS_ACK_A;
                        end else begin
                            s_d.st = BUS_IDLE;
                        end
                    end
                end
                BUS_ACK_A: begin
                    s_d.bitcnt = 4'h0;
                    if (s_q.rw) begin
                        s_d.shreg = rd_data;
                        s_d.sda_low = ~rd_data[7];
                        s_d.st = BUS_RDATA;
                    end else begin
                        s_d.sda_low = 1'b0;
                        s_d.st = BUS_WREG;
                    end
                end
                BUS_WREG: begin
                    if (s_q.bitcnt == 4'h8) begin
                        s_d.ptr = s_q.shreg;
                        s_d.sda_low = 1'b1;
                        s_d.st = BUS_ACK_W;
                    end
                end
                BUS_ACK_W: begin
                    s_d.bitcnt = 4'h0;
                    s_d.sda_low = 1'b0;
                    s_d.st = BUS_WDATA;
                end
                BUS_WDATA: begin
                    if (s_q.bitcnt == 4'h8) begin
                        s_d.ptr = s_q.ptr + 8'h01;
                        s_d.sda_low = 1'b1;
                        s_d.st = BUS_ACK_W;
                        if (s_q.ptr == OFS_OSC) begin
                            s_d.clk.oscillator_disable =
                                s_q.shreg[BIT_OSC_DIS];
                        end else if (s_q.ptr == OFS_CAL) begin
                            s_d.out_level = s_q.shreg[BIT_OUT];
                            s_d.clk.frequency_test_enable =
                                s_q.shreg[BIT_FT];
                            s_d.clk.cal_sign = s_q.shreg[BIT_CAL_SIGN];
                            s_d.clk.cal_value = s_q.shreg[4:0];
                        end else if (s_q.ptr == OFS_AUDIO) begin
                            s_d.aud.tone_512 = s_q.shreg[BIT_PITCH];
                            s_d.aud.tone_en = s_q.shreg[BIT_TONE_EN];
                            s_d.aud.mute = s_q.shreg[BIT_MUTE];
                            s_d.aud.volume = s_q.shreg[3:0];
                        end else if (s_q.ptr == OFS_CHARGE) begin
                            s_d.key = s_q.shreg[7:4];
                            s_d.diode = s_q.shreg[BIT_DIODE];
                            s_d.path = s_q.shreg[BIT_PATH];
                        end else if (s_q.ptr == OFS_FREEZE) begin
                            s_d.clk.transfer_freeze =
                                s_q.shreg[BIT_FREEZE];
                        end else if (s_q.ptr == OFS_FAIL) begin
                            s_d.clk.osc_fail_irq_enable =
                                s_q.shreg[BIT_IRQ_EN];
                            s_d.clk.osc_failure_flag = s_q.shreg[BIT_OF];
                        end
                    end
                end
                BUS_RDATA: begin
                    if (s_q.bitcnt == 4'h7) begin
                        s_d.sda_low = 1'b0;
                        s_d.ptr = s_q.ptr + 8'h01;
                        s_d.st = BUS_RACK;
                    end else begin
                        s_d.bitcnt = s_q.bitcnt + 4'h1;
                        s_d.shreg = {s_q.shreg[6:0], 1'b0};
                        s_d.sda_low = ~s_q.shreg[6];
                    end
                end
                BUS_RACK: begin
                    s_d.bitcnt = 4'h0;
                    if (s_q.rw) begin
                        s_d.st = BUS_IDLE;
                    end else begin
                        s_d.shreg = rd_data;
                        s_d.sda_low = ~rd_data[7];
                        s_d.st = BUS_RDATA;
                    end
                end
                default: begin
                    s_d.st = BUS_IDLE;
                end
            endcase
        end

        // A stopped oscillator sets the flag even during a clearing write
        if (s_q.of_s2) begin
            s_d.clk.osc_failure_flag = 1'b1;
        end

        // Tone generator, pitch picked by the tone_512 bit
        if (s_q.tone_cnt >= (s_q.aud.tone_512 ? HI_END : LO_END)) begin
            s_d.tone_cnt = '0;
            s_d.tone_q = ~s_q.tone_q;
        end else begin
            s_d.tone_cnt = s_q.tone_cnt + 1'b1;
        end

        // Fixed high-pitch square for the frequency test output
        if (s_q.ft_cnt >= HI_END) begin
            s_d.ft_cnt = '0;
            s_d.ft_q = ~s_q.ft_q;
        end else begin
            s_d.ft_cnt = s_q.ft_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State register; retained fields survive the power-on reset
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q.scl_s1 <= 1'b1;
            s_q.scl_s2 <= 1'b1;
            s_q.scl_p <= 1'b1;
            s_q.sda_s1 <= 1'b1;
            s_q.sda_s2 <= 1'b1;
            s_q.sda_p <= 1'b1;
            s_q.bk_s1 <= 1'b0;
            s_q.bk_s2 <= 1'b0;
            s_q.of_s1 <= 1'b0;
            s_q.of_s2 <= 1'b0;
            s_q.st <= BUS_IDLE;
            s_q.bitcnt <= 4'h0;
            s_q.shreg <= 8'h00;
            s_q.ptr <= 8'h00;
            s_q.rw <= 1'b0;
            s_q.sda_low <= 1'b0;
            s_q.init_cnt <= 2'h0;
            s_q.init_done <= 1'b0;
            s_q.tone_cnt <= '0;
            s_q.tone_q <= 1'b0;
            s_q.ft_cnt <= '0;
            s_q.ft_q <= 1'b0;
            s_q.aud.mute <= 1'b1;
            s_q.aud.tone_en <= 1'b0;
            s_q.clk.transfer_freeze <= 1'b1;
            s_q.clk.frequency_test_enable <= 1'b0;
            s_q.key <= KEY_PWRUP;
            s_q.diode <= 1'b0;
            s_q.path <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign sda_o = 1'b0;
    assign sda_oe_n_o = ~s_q.sda_low;
    assign audio_o = s_q.aud;
    assign amp_on_o = ~s_q.aud.mute;
    assign tone_sel_o = s_q.aud.tone_en;
    assign tone_o = s_q.tone_q & s_q.aud.tone_en & ~s_q.aud.mute;
    assign clock_o = s_q.clk;
    assign charge_o.charger_key_nibble = s_q.key;
    assign charge_o.charger_diode_switch = s_q.diode;
    assign charge_o.charger_path_enable = s_q.path;
    assign charge_o.charger_closed = s_q.path && (s_q.key == KEY_CLOSE);
    assign mfp_o = 1'b0;
    assign mfp_oe_n_o = s_q.clk.frequency_test_enable ? s_q.ft_q
                                                      : s_q.out_level;

endmodule

/* hw/rca_pkg.sv */
// Shared constants and types for the audio control and power-up block
package rca_pkg;

    // ------------------------------------------------------------
    // Clock and tone timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned TONE_LO_HZ = 256;
    localparam int unsigned TONE_HI_HZ = 512;
    localparam int unsigned HALF_LO_CYC = CLK_HZ / (2 * TONE_LO_HZ);
    localparam int unsigned HALF_HI_CYC = CLK_HZ / (2 * TONE_HI_HZ);
    localparam int unsigned TONE_CNT_W = 17;

    // ------------------------------------------------------------
    // Serial bus and register map
    // ------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR_DEF = 7'h68;
    localparam logic [7:0] OFS_OSC = 8'h00;
    localparam logic [7:0] OFS_CAL = 8'h07;
    localparam logic [7:0] OFS_AUDIO = 8'h08;
    localparam logic [7:0] OFS_CHARGE = 8'h09;
    localparam logic [7:0] OFS_FREEZE = 8'h0c;
    localparam logic [7:0] OFS_FAIL = 8'h0f;

    // Field positions
    localparam int BIT_OSC_DIS = 7;
    localparam int BIT_OUT = 7;
    localparam int BIT_FT = 6;
    localparam int BIT_CAL_SIGN = 5;
    localparam int BIT_PITCH = 7;
    localparam int BIT_TONE_EN = 6;
    localparam int BIT_MUTE = 4;
    localparam int BIT_DIODE = 3;
    localparam int BIT_PATH = 2;
    localparam int BIT_FREEZE = 6;
    localparam int BIT_IRQ_EN = 7;
    localparam int BIT_OF = 2;

    // Power-up values, charger close key and power-up wait count
    localparam logic [3:0] VOL_FIRST = 4'h0;
    localparam logic [3:0] KEY_PWRUP = 4'ha;
    localparam logic [3:0] KEY_CLOSE = 4'h5;
    localparam logic [4:0] CAL_FIRST = 5'h00;
    localparam logic [1:0] INIT_WAIT = 2'h3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_ADDR = 3'b001,
        BUS_ACK_A = 3'b010,
        BUS_WREG = 3'b011,
        BUS_ACK_W = 3'b100,
        BUS_WDATA = 3'b101,
        BUS_RDATA = 3'b110,
        BUS_RACK = 3'b111
    } rca_bus_st_t;

    typedef struct packed {
        logic tone_512;
        logic tone_en;
        logic mute;
        logic [3:0] volume;
    } rca_audio_t;

    typedef struct packed {
        logic oscillator_disable;
        logic transfer_freeze;
        logic frequency_test_enable;
        logic osc_failure_flag;
        logic osc_fail_irq_enable;
        logic cal_sign;
        logic [4:0] cal_value;
    } rca_clock_t;

    typedef struct packed {
        logic [3:0] charger_key_nibble;
        logic charger_diode_switch;
        logic charger_path_enable;
        logic charger_closed;
    } rca_charge_t;

endpackage

/* verif/rca_ctrl_checker.sv */
// Port-level assertions for the audio control and power-up block
module rca_ctrl_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic backup_kept_i,
    input wire rca_pkg::rca_audio_t audio_o,
    input wire logic amp_on_o,
    input wire logic tone_sel_o,
    input wire logic tone_o,
    input wire rca_pkg::rca_clock_t clock_o,
    input wire rca_pkg::rca_charge_t charge_o,
    input wire logic mfp_oe_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import rca_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------
    // Audio path
    // ------------------------------------------------------------
    property p_amp_mute;
        $stable(audio_o.mute) |-> amp_on_o == !audio_o.mute;
    endproperty
    a_amp_mute: assert property (p_amp_mute)
        else $error("amplifier enable disagrees with silence bit");
    property p_tone_gate;
        (audio_o.mute || !audio_o.tone_en) [*2] |-> !tone_o;
    endproperty
    a_tone_gate: assert property (p_tone_gate)
        else $error("tone active while silenced or disabled");
    property p_tone_sel;
        $stable(audio_o.tone_en) |-> tone_sel_o == audio_o.tone_en;
    endproperty
    a_tone_sel: assert property (p_tone_sel)
        else $error("tone path select disagrees with tone enable");

    // ------------------------------------------------------------
    // Power-up values
    // ------------------------------------------------------------
    property p_up_audio;
        $fell(rst_i) |-> audio_o.mute && !audio_o.tone_en && !amp_on_o;
    endproperty
    a_up_audio: assert property (p_up_audio)
        else $error("audio not silenced after power-up");
    property p_up_clock;
        $fell(rst_i) |-> clock_o.transfer_freeze
            && !clock_o.frequency_test_enable;
    endproperty
    a_up_clock: assert property (p_up_clock)
        else $error("freeze or frequency test wrong after power-up");
    property p_up_charge;
        $fell(rst_i) |-> charge_o.charger_key_nibble == KEY_PWRUP
            && !charge_o.charger_diode_switch
            && !charge_o.charger_path_enable && !charge_o.charger_closed;
    endproperty
    a_up_charge: assert property (p_up_charge)
        else $error("charger not opened after power-up");
    property p_first;
        $fell(rst_i) && !backup_kept_i |-> ##6 (audio_o.volume == VOL_FIRST
            && audio_o.tone_512 && !clock_o.oscillator_disable
            && clock_o.osc_failure_flag && !clock_o.osc_fail_irq_enable
            && clock_o.cal_value == CAL_FIRST && !clock_o.cal_sign
            && mfp_oe_n_o);
    endproperty
    a_first: assert property (p_first)
        else $error("first power-up values not loaded");
    property p_later;
        $fell(rst_i) && backup_kept_i |-> ##6
            (audio_o.volume == $past(audio_o.volume, 6)
            && audio_o.tone_512 == $past(audio_o.tone_512, 6)
            && clock_o.cal_value == $past(clock_o.cal_value, 6));
    endproperty
    a_later: assert property (p_later)
        else $error("retained fields changed on later power-up");
    property p_closed;
        $stable(charge_o) |-> charge_o.charger_closed
            == (charge_o.charger_path_enable
            && charge_o.charger_key_nibble == KEY_CLOSE);
    endproperty
    a_closed: assert property (p_closed)
        else $error("charger switch state disagrees with key");
endmodule

/* verif/rca_host.sv */
// Two-wire bus host model that drives the device's serial pins
module rca_host #(
    parameter logic [6:0] DEV = rca_pkg::DEV_ADDR_DEF
) (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Clock line stands high between frames
    initial begin
        scl_o = 1'b1;
        sda_oe_n_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_oe_n_o = b;
        tick(6);
        scl_o = 1'b1;
        tick(3);
        r = sda_i;
        tick(3);
        scl_o = 1'b0;
        tick(2);
    endtask
    task automatic start();
        sda_oe_n_o = 1'b1;
        tick(6);
        scl_o = 1'b1;
        tick(6);
        sda_oe_n_o = 1'b0;
        tick(6);
        scl_o = 1'b0;
        tick(2);
    endtask
    task automatic stop();
        sda_oe_n_o = 1'b0;
        tick(6);
        scl_o = 1'b1;
        tick(6);
        sda_oe_n_o = 1'b1;
        tick(6);
    endtask
    // Eight bits MSB first, then the acknowledge slot
    task automatic xbyte(input logic [7:0] d, output logic [7:0] q,
            output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic wr(input logic [6:0] dev, input logic [7:0] ofs,
            input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic a0, a1, a2;
        start();
        xbyte({dev, 1'b0}, q, a0);
        xbyte(ofs, q, a1);
        xbyte(d, q, a2);
        stop();
        ok = a0 && a1 && a2;
    endtask
    task automatic rd(input logic [7:0] ofs, output logic [7:0] q);
        logic [7:0] x;
        logic a;
        start();
        xbyte({DEV, 1'b0}, x, a);
        xbyte(ofs, x, a);
        start();
        xbyte({DEV, 1'b1}, x, a);
        xbyte(8'hff, q, a);
        stop();
    endtask
endmodule

/* verif/test_rca_ctrl.sv */
// Self-checking bench for the audio control and power-up block
module test_rca_ctrl import rca_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic backup_kept_i = 1'b0;
    logic osc_stopped_i = 1'b0;
    logic scl, host_oe_n, sda_oe_n_o, amp_on_o, tone_sel_o, tone_o;
    logic mfp_oe_n_o;
    rca_audio_t audio_o;
    rca_clock_t clock_o;
    rca_charge_t charge_o;
    wire sda_w;
    int n_errors = 0;
    int checks = 0;
    // Open-drain data line with pull-up
    assign sda_w = host_oe_n & sda_oe_n_o;
    rca_ctrl #(.HALF_LO(8), .HALF_HI(4)) uut (.clk_i(clk_i),
        .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(),
        .sda_oe_n_o(sda_oe_n_o), .backup_kept_i(backup_kept_i),
        .osc_stopped_i(osc_stopped_i), .audio_o(audio_o),
        .amp_on_o(amp_on_o), .tone_sel_o(tone_sel_o), .tone_o(tone_o),
        .clock_o(clock_o), .charge_o(charge_o), .mfp_o(),
        .mfp_oe_n_o(mfp_oe_n_o));
    rca_host host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl),
        .sda_oe_n_o(host_oe_n));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
            input logic [15:0] g);
        checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    task automatic w(input logic [7:0] ofs, input logic [7:0] d);
        logic ok;
        host.wr(DEV_ADDR_DEF, ofs, d, ok);
        chk("write ack", 16'h1, {15'h0, ok});
    endtask
    task automatic rchk(input logic [7:0] ofs, input logic [7:0] e);
        logic [7:0] q;
        host.rd(ofs, q);
        chk("register read", {8'h0, e}, {8'h0, q});
    endtask
    task automatic power_up(input logic kept);
        backup_kept_i = kept;
        rst_i = 1'b1;
        tick(3);
        rst_i = 1'b0;
        tick(10);
    endtask
    // Cycles between two changes of the tone output, 100 if none
    task automatic half(output int n);
        logic p;
        int k;
        n = 0;
        k = 0;
        p = tone_o;
        while (tone_o === p && k < 100) begin
            tick(1);
            k++;
        end
        p = tone_o;
        while (tone_o === p && n < 100) begin
            tick(1);
            n++;
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_first();
        power_up(1'b0);
        chk("audio", 16'h50, {9'h0, audio_o});
        chk("clock", 16'h280, {5'h0, clock_o});
        chk("charge", 16'h50, {9'h0, charge_o});
        chk("pin released", 16'h1, {15'h0, mfp_oe_n_o});
        rchk(8'h08, 8'h90);
        rchk(8'h07, 8'h80);
        rchk(8'h0f, 8'h04);
        rchk(8'h03, 8'h00);
        $display("first power-up test done");
    endtask
    task automatic t_audio();
        logic ok;
        int n;
        for (int c = 0; c < 16; c++) begin
            w(8'h08, c[7:0]);
            chk("volume", c[15:0], {12'h0, audio_o.volume});
            chk("amp on", 16'h1, {15'h0, amp_on_o});
        end
        w(8'h08, 8'h1f);
        chk("amp muted", 16'h0, {15'h0, amp_on_o});
        host.wr(7'h11, 8'h08, 8'h05, ok);
        chk("foreign address", 16'h1f, {9'h0, audio_o});
        w(8'h08, 8'hc0);
        chk("tone select", 16'h1, {15'h0, tone_sel_o});
        half(n);
        chk("512 Hz half period", 16'd4, n[15:0]);
        w(8'h08, 8'h40);
        half(n);
        chk("256 Hz half period", 16'd8, n[15:0]);
        w(8'h08, 8'h50);
        half(n);
        chk("silenced tone", 16'd100, n[15:0]);
        $display("audio test done");
    endtask
    task automatic t_later();
        w(8'h0c, 8'h00);
        chk("freeze", 16'h0, {15'h0, clock_o.transfer_freeze});
        w(8'h00, 8'h80);
        w(8'h07, 8'h75);
        chk("ft", 16'h1, {15'h0, clock_o.frequency_test_enable});
        w(8'h09, 8'h5c);
        chk("closed", 16'h1, {15'h0, charge_o.charger_closed});
        w(8'h0f, 8'h00);
        w(8'h08, 8'h4b);
        power_up(1'b1);
        chk("audio", 16'h1b, {9'h0, audio_o});
        chk("clock", 16'h635, {5'h0, clock_o});
        chk("charge", 16'h50, {9'h0, charge_o});
        chk("pin kept low", 16'h0, {15'h0, mfp_oe_n_o});
        osc_stopped_i = 1'b1;
        tick(5);
        osc_stopped_i = 1'b0;
        tick(5);
        chk("osc fail", 16'h1, {15'h0, clock_o.osc_failure_flag});
        $display("later power-up test done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        tick(50000);
        n_errors++;
        results();
    end
    initial begin
        t_first();
        t_audio();
        t_later();
        results();
    end
endmodule

bind rca_ctrl rca_ctrl_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .backup_kept_i(backup_kept_i), .audio_o(audio_o),
    .amp_on_o(amp_on_o), .tone_sel_o(tone_sel_o), .tone_o(tone_o),
    .clock_o(clock_o), .charge_o(charge_o), .mfp_oe_n_o(mfp_oe_n_o));
